// ===== gppv_top.sv
// Overview of operation
// - Bit 7 drives bidirectional pin in output mode
// - Bit 6 drives output pin one
// - Bit 5 drives output pin two
// - Bit 4 drives output pin three
// - Bit 3 drives output pin four
// - Stored zero drives low, one drives high
// - Monitor bit 7 shows bidirectional pin input level
// - Bits 6:4 select input pin one function
// - Code 3 routes pin to daisy-chain input
// - Codes 4-7 route pin to PDM pairs
// - Bits 2:0 select input pin two function
// - Pin two code 1 is observable input
// - Drive value register resets to zero
// - Second select register at 0x2c, resets zero
// - Second register selects pins three and four
// - Input monitor reports pins one-four in 7:4
// - Drive value only acts in output mode
`timescale 1ns/100ps
`default_nettype none

module gppv_top (
   input  wire logic                          mclk_i,
   input  wire logic                          rst_b_i,
   input  wire logic [gppv_pkg::ADDR_W-1:0]   reg_addr_i,
   input  wire logic                          reg_wr_i,
   input  wire logic                          reg_rd_i,
   input  wire logic [gppv_pkg::DATA_W-1:0]   reg_wdata_i,
   output logic      [gppv_pkg::DATA_W-1:0]   reg_rdata_o,
   input  wire logic [gppv_pkg::OUT_FN_W-1:0] bidir_pin_one_function_i,
   input  wire logic [gppv_pkg::OUT_FN_W-1:0] out_pin_one_function_i,
   input  wire logic [gppv_pkg::OUT_FN_W-1:0] out_pin_two_function_i,
   input  wire logic [gppv_pkg::OUT_FN_W-1:0] out_pin_three_function_i,
   input  wire logic [gppv_pkg::OUT_FN_W-1:0] out_pin_four_function_i,
   input  wire logic                          bidir_pin_one_i,
   output logic                               bidir_pin_one_o,
   output logic                               bidir_pin_one_oe_o,
   output logic                               out_pin_one_o,
   output logic                               out_pin_one_oe_o,
   output logic                               out_pin_two_o,
   output logic                               out_pin_two_oe_o,
   output logic                               out_pin_three_o,
   output logic                               out_pin_three_oe_o,
   output logic                               out_pin_four_o,
   output logic                               out_pin_four_oe_o,
   input  wire logic                          in_pin_one_i,
   input  wire logic                          in_pin_two_i,
   input  wire logic                          in_pin_three_i,
   input  wire logic                          in_pin_four_i,
   output logic                               mclk_o,
   output logic                               mclk_valid_o,
   output logic                               daisy_chain_serial_input_o,
   output logic                               daisy_chain_valid_o,
   output logic      [3:0]                    pdm_data_o,
   output logic      [3:0]                    pdm_data_valid_o
);
   import gppv_pkg::*;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [FN_W-1:0] fsel_field(input logic [DATA_W-1:0] r,
                                                  input int lo);
      return r[lo +: FN_W];
   endfunction

   function automatic logic is_gpo(input logic [OUT_FN_W-1:0] fn);
      return fn == OUT_FN_GPO;
   endfunction

   // ---------------------------------------------------------------
   // Storage
   // ---------------------------------------------------------------
   logic [DATA_W-1:0] drive_r;
   logic [DATA_W-1:0] fsel_a_r;
   logic [DATA_W-1:0] fsel_b_r;
   logic              bidir_mon_r;
   logic [DATA_W-1:0] rdata_nxt;
   logic [NUM_OUT-1:0] out_o;
   logic [NUM_OUT-1:0] out_oe;
   logic [NUM_IN-1:0]  in_pins;

   gppv_cfg_if cfg ();

   assign in_pins = {in_pin_four_i, in_pin_three_i, in_pin_two_i, in_pin_one_i};

   // ---------------------------------------------------------------
   // Register writes
   // ---------------------------------------------------------------
   // Masking on write keeps reserved bits at zero for good
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         drive_r <= RST_VAL;
      end else if (reg_wr_i && reg_addr_i == OFF_DRIVE) begin
         drive_r <= reg_wdata_i & DRIVE_WMASK;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         fsel_a_r <= RST_VAL;
      end else if (reg_wr_i && reg_addr_i == OFF_FSEL_A) begin
         fsel_a_r <= reg_wdata_i & FSEL_WMASK;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         fsel_b_r <= RST_VAL;
      end else if (reg_wr_i && reg_addr_i == OFF_FSEL_B) begin
         fsel_b_r <= reg_wdata_i & FSEL_WMASK;
      end
   end

   // ---------------------------------------------------------------
   // Configuration towards the pin logic
   // ---------------------------------------------------------------
   assign cfg.drive_bidir = drive_r[BIT_BIDIR_VAL];
   assign cfg.drive_out   = {drive_r[BIT_OUT_ONE-3],
                             drive_r[BIT_OUT_ONE-2],
                             drive_r[BIT_OUT_ONE-1],
                             drive_r[BIT_OUT_ONE]};
   assign cfg.bidir_gpo   = is_gpo(bidir_pin_one_function_i);
   assign cfg.out_gpo     = {is_gpo(out_pin_four_function_i),
                             is_gpo(out_pin_three_function_i),
                             is_gpo(out_pin_two_function_i),
                             is_gpo(out_pin_one_function_i)};
   assign cfg.in_fn[0]    = fsel_field(fsel_a_r, FSEL_HI_LO);
   assign cfg.in_fn[1]    = fsel_field(fsel_a_r, FSEL_LO_LO);
   assign cfg.in_fn[2]    = fsel_field(fsel_b_r, FSEL_HI_LO);
   assign cfg.in_fn[3]    = fsel_field(fsel_b_r, FSEL_LO_LO);

   // ---------------------------------------------------------------
   // Bidirectional pin monitor
   // ---------------------------------------------------------------
   // Reads zero outside input mode so stale levels never show
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         bidir_mon_r <= 1'b0;
      end else begin
         bidir_mon_r <= (bidir_pin_one_function_i == BIDIR_FN_GPI) & bidir_pin_one_i;
      end
   end

   // ---------------------------------------------------------------
   // Register reads
   // ---------------------------------------------------------------
   always_comb begin
      rdata_nxt = RST_VAL;
      case (reg_addr_i)
         OFF_DRIVE:     rdata_nxt = drive_r;
         OFF_BIDIR_MON: rdata_nxt[BIT_BIDIR_MON] = bidir_mon_r;
         OFF_FSEL_A:    rdata_nxt = fsel_a_r;
         OFF_FSEL_B:    rdata_nxt = fsel_b_r;
         OFF_IN_MON: begin
            for (int i = 0; i < NUM_IN; i++) begin
               rdata_nxt[IN_MON_LO + NUM_IN - 1 - i] = cfg.in_lvl[i];
            end
         end
         default:       rdata_nxt = RST_VAL;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= RST_VAL;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_nxt;
      end
   end

   // ---------------------------------------------------------------
   // Pin logic
   // ---------------------------------------------------------------
   gppv_pin_drive u_drive (
      .mclk_i     (mclk_i),
      .rst_b_i    (rst_b_i),
      .cfg        (cfg.drive),
      .bidir_o    (bidir_pin_one_o),
      .bidir_oe_o (bidir_pin_one_oe_o),
      .out_o      (out_o),
      .out_oe_o   (out_oe)
   );

   assign {out_pin_four_o, out_pin_three_o, out_pin_two_o, out_pin_one_o} = out_o;
   assign {out_pin_four_oe_o, out_pin_three_oe_o,
           out_pin_two_oe_o, out_pin_one_oe_o} = out_oe;

   gppv_in_route u_route (
      .mclk_i        (mclk_i),
      .rst_b_i       (rst_b_i),
      .cfg           (cfg.route),
      .pins_i        (in_pins),
      .mclk_o        (mclk_o),
      .mclk_valid_o  (mclk_valid_o),
      .daisy_o       (daisy_chain_serial_input_o),
      .daisy_valid_o (daisy_chain_valid_o),
      .pdm_o         (pdm_data_o),
      .pdm_valid_o   (pdm_data_valid_o)
   );

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);

   reset_to_zero_a: assert property (
      @(posedge mclk_i) disable iff (1'b0)
      !rst_b_i |=> (drive_r == RST_VAL && fsel_a_r == RST_VAL && fsel_b_r == RST_VAL))
      else $error("registers not zero after reset");

   second_sel_write_a: assert property (
      reg_wr_i && reg_addr_i == OFF_FSEL_B ##1 reg_rd_i && reg_addr_i == OFF_FSEL_B
      && !reg_wr_i
      |=> reg_rdata_o == ($past(reg_wdata_i, 2) & FSEL_WMASK))
      else $error("second select register readback wrong");

   bidir_drive_a: assert property (
      is_gpo(bidir_pin_one_function_i)
      |=> bidir_pin_one_oe_o && bidir_pin_one_o == $past(drive_r[BIT_BIDIR_VAL]))
      else $error("bidirectional pin not driven with stored level");

   out_four_drive_a: assert property (
      is_gpo(out_pin_four_function_i) && drive_r[BIT_OUT_ONE-3]
      |=> out_pin_four_oe_o && out_pin_four_o)
      else $error("output pin four not driven high");

   out_one_low_a: assert property (
      is_gpo(out_pin_one_function_i) && !drive_r[BIT_OUT_ONE]
      |=> out_pin_one_oe_o && !out_pin_one_o)
      else $error("output pin one not driven low");

   drive_mode_gate_a: assert property (
      !is_gpo(out_pin_two_function_i) |=> !out_pin_two_oe_o)
      else $error("output pin two driven outside output mode");

   bidir_monitor_a: assert property (
      bidir_pin_one_function_i == BIDIR_FN_GPI ##1 reg_rd_i && reg_addr_i == OFF_BIDIR_MON
      && bidir_pin_one_function_i == BIDIR_FN_GPI
      |=> reg_rdata_o[BIT_BIDIR_MON] == $past(bidir_pin_one_i, 2))
      else $error("bidirectional monitor level wrong");

   mclk_route_a: assert property (
      cfg.in_fn[0] == FN_MCLK |=> mclk_valid_o && mclk_o == $past(in_pin_one_i))
      else $error("pin one not routed as master clock");

   daisy_route_a: assert property (
      cfg.in_fn[0] == FN_DAISY |=> daisy_chain_valid_o
      && daisy_chain_serial_input_o == $past(in_pin_one_i))
      else $error("pin one not routed as daisy-chain input");

   pdm_route_a: assert property (
      cfg.in_fn[0][FN_W-1] |=> pdm_data_valid_o[$past(cfg.in_fn[0][1:0])]
      && pdm_data_o[$past(cfg.in_fn[0][1:0])] == $past(in_pin_one_i))
      else $error("pin one not routed as PDM data");

   pin_two_gpi_a: assert property (
      cfg.in_fn[1] == FN_GPI ##1 reg_rd_i && reg_addr_i == OFF_IN_MON
      |=> reg_rdata_o[IN_MON_LO + NUM_IN - 2] == $past(in_pin_two_i, 2))
      else $error("pin two general input level not reported");

   reserved_zero_a: assert property (
      reg_rd_i && reg_addr_i == OFF_DRIVE |=> reg_rdata_o[2:0] == 3'h0)
      else $error("reserved drive bits not zero");

   pin_four_sel_a: assert property (
      cfg.in_fn[3] == FN_MCLK && cfg.in_fn[0] != FN_MCLK && cfg.in_fn[1] != FN_MCLK
      && cfg.in_fn[2] != FN_MCLK |=> mclk_valid_o && mclk_o == $past(in_pin_four_i))
      else $error("pin four not routed as master clock");

   out_one_high_a: assert property (
      is_gpo(out_pin_one_function_i) && drive_r[BIT_OUT_ONE]
      |=> out_pin_one_oe_o && out_pin_one_o)
      else $error("output pin one not driven high");

   out_two_drive_a: assert property (
      is_gpo(out_pin_two_function_i)
      |=> out_pin_two_oe_o && out_pin_two_o == $past(drive_r[BIT_OUT_ONE-1]))
      else $error("output pin two not driven with stored level");

   out_three_drive_a: assert property (
      is_gpo(out_pin_three_function_i)
      |=> out_pin_three_oe_o && out_pin_three_o == $past(drive_r[BIT_OUT_ONE-2]))
      else $error("output pin three not driven with stored level");

   out_four_gate_a: assert property (
      !is_gpo(out_pin_four_function_i) |=> !out_pin_four_oe_o && !out_pin_four_o)
      else $error("output pin four driven outside output mode");

   pin_two_daisy_a: assert property (
      cfg.in_fn[1] == FN_DAISY && cfg.in_fn[0] != FN_DAISY |=> daisy_chain_valid_o
      && daisy_chain_serial_input_o == $past(in_pin_two_i))
      else $error("pin two not routed as daisy-chain input");

   pin_three_pdm_a: assert property (
      cfg.in_fn[2] == FN_PDM2 && cfg.in_fn[0] != FN_PDM2 && cfg.in_fn[1] != FN_PDM2
      |=> pdm_data_valid_o[1] && pdm_data_o[1] == $past(in_pin_three_i))
      else $error("pin three not routed as PDM data");

   in_mon_gate_a: assert property (
      cfg.in_fn[2] != FN_GPI ##1 reg_rd_i && reg_addr_i == OFF_IN_MON
      |=> !reg_rdata_o[IN_MON_LO + 1])
      else $error("pin three level shown outside input mode");

   mon_reserved_a: assert property (
      reg_rd_i && reg_addr_i == OFF_BIDIR_MON |=> reg_rdata_o[BIT_BIDIR_MON-1:0] == '0)
      else $error("reserved monitor bits not zero");

   drive_hold_a: assert property (
      !(reg_wr_i && reg_addr_i == OFF_DRIVE) |=> drive_r == $past(drive_r))
      else $error("drive register changed without a write");

   drive_write_c: cover property (reg_wr_i && reg_addr_i == OFF_DRIVE ##2 out_pin_one_o);
   pdm_pair_c:    cover property (cfg.in_fn[2] == FN_PDM4 ##1 pdm_data_valid_o[3]);
   gpi_read_c:    cover property (cfg.in_fn[0] == FN_GPI ##1 reg_rd_i
                                  && reg_addr_i == OFF_IN_MON);
   bidir_gpi_c:   cover property (bidir_pin_one_function_i == BIDIR_FN_GPI ##1 reg_rd_i
                                  && reg_addr_i == OFF_BIDIR_MON);

endmodule // gppv_top

`default_nettype wire

// ===== gppv_pkg.sv
`default_nettype none

package gppv_pkg;

   // ---------------------------------------------------------------
   // Register port geometry
   // ---------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;

   // ---------------------------------------------------------------
   // Register offsets and reset value
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_DRIVE     = 8'h29;
   localparam logic [ADDR_W-1:0] OFF_BIDIR_MON = 8'h2a;
   localparam logic [ADDR_W-1:0] OFF_FSEL_A    = 8'h2b;
   localparam logic [ADDR_W-1:0] OFF_FSEL_B    = 8'h2c;
   localparam logic [ADDR_W-1:0] OFF_IN_MON    = 8'h2f;
   localparam logic [DATA_W-1:0] RST_VAL       = 8'h00;

   // ---------------------------------------------------------------
   // Field layout
   // ---------------------------------------------------------------
   localparam logic [DATA_W-1:0] DRIVE_WMASK   = 8'hf8;
   localparam logic [DATA_W-1:0] FSEL_WMASK    = 8'h77;
   localparam int                BIT_BIDIR_VAL = 7;
   localparam int                BIT_OUT_ONE   = 6;
   localparam int                BIT_BIDIR_MON = 7;
   localparam int                FSEL_HI_LO    = 4;
   localparam int                FSEL_LO_LO    = 0;
   localparam int                IN_MON_LO     = 4;
   localparam int                NUM_OUT       = 4;
   localparam int                NUM_IN        = 4;
   localparam int                FN_W          = 3;
   localparam int                OUT_FN_W      = 4;

   // ---------------------------------------------------------------
   // Function codes
   // ---------------------------------------------------------------
   localparam logic [OUT_FN_W-1:0] OUT_FN_GPO   = 4'h1;
   localparam logic [OUT_FN_W-1:0] BIDIR_FN_GPI = 4'h2;

   typedef enum logic [FN_W-1:0] {
      FN_OFF,
      FN_GPI,
      FN_MCLK,
      FN_DAISY,
      FN_PDM1,
      FN_PDM2,
      FN_PDM3,
      FN_PDM4
   } gppv_in_fn_t;

endpackage

`default_nettype wire

// ===== gppv_cfg_if.sv
`timescale 1ns/100ps
`default_nettype none

interface gppv_cfg_if;
   import gppv_pkg::*;

   logic                drive_bidir;
   logic [NUM_OUT-1:0]  drive_out;
   logic                bidir_gpo;
   logic [NUM_OUT-1:0]  out_gpo;
   logic [FN_W-1:0]     in_fn [NUM_IN];
   logic [NUM_IN-1:0]   in_lvl;

   modport regs  (output drive_bidir, drive_out, bidir_gpo, out_gpo, in_fn, input in_lvl);
   modport drive (input drive_bidir, drive_out, bidir_gpo, out_gpo);
   modport route (input in_fn, output in_lvl);
endinterface

`default_nettype wire

// ===== gppv_pin_drive.sv
`timescale 1ns/100ps
`default_nettype none

module gppv_pin_drive (
   input  wire logic                         mclk_i,
   input  wire logic                         rst_b_i,
   gppv_cfg_if.drive                         cfg,
   output logic                              bidir_o,
   output logic                              bidir_oe_o,
   output logic [gppv_pkg::NUM_OUT-1:0]      out_o,
   output logic [gppv_pkg::NUM_OUT-1:0]      out_oe_o
);
   import gppv_pkg::*;

   // Pins only drive while in output mode; value is the stored level
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         bidir_o    <= 1'b0;
         bidir_oe_o <= 1'b0;
      end else begin
         bidir_o    <= cfg.bidir_gpo & cfg.drive_bidir;
         bidir_oe_o <= cfg.bidir_gpo;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         out_o    <= '0;
         out_oe_o <= '0;
      end else begin
         out_o    <= cfg.out_gpo & cfg.drive_out;
         out_oe_o <= cfg.out_gpo;
      end
   end

endmodule // gppv_pin_drive

`default_nettype wire

// ===== gppv_in_route.sv
`timescale 1ns/100ps
`default_nettype none

module gppv_in_route (
   input  wire logic                        mclk_i,
   input  wire logic                        rst_b_i,
   gppv_cfg_if.route                        cfg,
   input  wire logic [gppv_pkg::NUM_IN-1:0] pins_i,
   output logic                             mclk_o,
   output logic                             mclk_valid_o,
   output logic                             daisy_o,
   output logic                             daisy_valid_o,
   output logic [3:0]                       pdm_o,
   output logic [3:0]                       pdm_valid_o
);
   import gppv_pkg::*;

   // Lowest numbered pin wins when two pins claim one function
   function automatic logic [1:0] pick(input logic [NUM_IN*FN_W-1:0] fns,
                                       input logic [NUM_IN-1:0] lvl,
                                       input gppv_in_fn_t code);
      logic [1:0] res;
      res = 2'b00;
      for (int i = NUM_IN - 1; i >= 0; i--) begin
         if (fns[i*FN_W +: FN_W] == code) begin
            res = {1'b1, lvl[i]};
         end
      end
      return res;
   endfunction

   logic [NUM_IN*FN_W-1:0] fns;
   logic [1:0]             p_mclk;
   logic [1:0]             p_daisy;
   logic [1:0]             p_pdm [4];

   always_comb begin
      for (int i = 0; i < NUM_IN; i++) begin
         fns[i*FN_W +: FN_W] = cfg.in_fn[i];
      end
   end

   assign p_mclk  = pick(fns, pins_i, FN_MCLK);
   assign p_daisy = pick(fns, pins_i, FN_DAISY);
   assign p_pdm[0] = pick(fns, pins_i, FN_PDM1);
   assign p_pdm[1] = pick(fns, pins_i, FN_PDM2);
   assign p_pdm[2] = pick(fns, pins_i, FN_PDM3);
   assign p_pdm[3] = pick(fns, pins_i, FN_PDM4);

   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         {mclk_valid_o, mclk_o}   <= 2'b00;
         {daisy_valid_o, daisy_o} <= 2'b00;
         pdm_o                    <= '0;
         pdm_valid_o              <= '0;
      end else begin
         {mclk_valid_o, mclk_o}   <= p_mclk;
         {daisy_valid_o, daisy_o} <= p_daisy;
         for (int k = 0; k < 4; k++) begin
            {pdm_valid_o[k], pdm_o[k]} <= p_pdm[k];
         end
      end
   end

   // Monitor reads zero unless the pin is a general input
   always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
         cfg.in_lvl <= '0;
      end else begin
         for (int i = 0; i < NUM_IN; i++) begin
            cfg.in_lvl[i] <= (cfg.in_fn[i] == FN_GPI) & pins_i[i];
         end
      end
   end

endmodule // gppv_in_route

`default_nettype wire

// ===== gppv_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module gppv_pin_model (
   input  wire logic       drv_i,
   input  wire logic       drv_oe_i,
   input  wire logic       ext_lvl_i,
   input  wire logic [3:0] in_lvl_i,
   output logic            bidir_wire_o,
   output logic [3:0]      in_pins_o
);
   // ---------------------------------------------------------------
   // Outside circuits on the pins
   // ---------------------------------------------------------------
   // Device wins while its enable is high, else the outside source sets the wire
   assign bidir_wire_o = drv_oe_i ? drv_i : ext_lvl_i;
   assign in_pins_o    = in_lvl_i;
endmodule // gppv_pin_model

`default_nettype wire

// ===== gppv_top_bench.sv
`timescale 1ns/100ps
`default_nettype none

module gppv_top_bench;
   import gppv_pkg::*;

   logic            mclk_i, rst_b_i, reg_wr_i, reg_rd_i, ext_lvl, bwire, bo, boe;
   logic            mo, mv, dd, dv;
   logic [7:0]      reg_addr_i, reg_wdata_i, reg_rdata_o, d, v, rv;
   logic [3:0]      in_lvl, pins, po, poe, pd, pv, lv, f;
   logic [4:0][3:0] ofn;
   logic [9:0]      de;
   logic [11:0]     re;
   int              err_total, checked;

   gppv_top gppv_top_inst (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
      .reg_rdata_o(reg_rdata_o), .bidir_pin_one_function_i(ofn[0]),
      .out_pin_one_function_i(ofn[1]), .out_pin_two_function_i(ofn[2]),
      .out_pin_three_function_i(ofn[3]), .out_pin_four_function_i(ofn[4]),
      .bidir_pin_one_i(bwire), .bidir_pin_one_o(bo), .bidir_pin_one_oe_o(boe),
      .out_pin_one_o(po[0]), .out_pin_one_oe_o(poe[0]), .out_pin_two_o(po[1]),
      .out_pin_two_oe_o(poe[1]), .out_pin_three_o(po[2]), .out_pin_three_oe_o(poe[2]),
      .out_pin_four_o(po[3]), .out_pin_four_oe_o(poe[3]), .in_pin_one_i(pins[0]),
      .in_pin_two_i(pins[1]), .in_pin_three_i(pins[2]), .in_pin_four_i(pins[3]),
      .mclk_o(mo), .mclk_valid_o(mv), .daisy_chain_serial_input_o(dd),
      .daisy_chain_valid_o(dv), .pdm_data_o(pd), .pdm_data_valid_o(pv));

   gppv_pin_model gppv_pin_model_inst (.drv_i(bo), .drv_oe_i(boe), .ext_lvl_i(ext_lvl),
      .in_lvl_i(in_lvl), .bidir_wire_o(bwire), .in_pins_o(pins));

   // ---------------------------------------------------------------
   // Expectations
   // ---------------------------------------------------------------
   function automatic logic [9:0] drive_exp(input logic [7:0] dv_in, input logic [4:0][3:0] fo);
      logic [9:0] e;
      e    = '0;
      e[9] = (fo[0] == OUT_FN_GPO);
      e[8] = dv_in[7] & e[9];
      for (int k = 0; k < 4; k++) begin
         e[4+k] = (fo[k+1] == OUT_FN_GPO);
         e[k]   = dv_in[6-k] & e[4+k];
      end
      return e;
   endfunction

   // Data is only meaningful under its valid, so callers mask it the same way
   function automatic logic [11:0] route_exp(input logic [2:0] c, input logic l);
      logic [3:0] pe;
      pe = (c >= 3'h4) ? 4'(1 << (c - 3'h4)) : 4'h0;
      return {c == 3'h2, l & (c == 3'h2), c == 3'h3, l & (c == 3'h3), pe, pe & {4{l}}};
   endfunction

   // ---------------------------------------------------------------
   // Bus tasks and reporting
   // ---------------------------------------------------------------
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      @(posedge mclk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= wd;
      @(posedge mclk_i);
      reg_wr_i    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] rd_v);
      @(posedge mclk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge mclk_i);
      reg_rd_i   <= 1'b0;
      #1 rd_v = reg_rdata_o;
   endtask

   task automatic conclude();
      $display("Counts: %0d checks, %0d mismatches", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and tests
   // ---------------------------------------------------------------
   initial begin
      mclk_i = 1'b0;
      forever #10 mclk_i = ~mclk_i;
   end

   // Tests need well under 10k cycles, so this only trips on a hang
   initial begin
      #200000;
      err_total++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      conclude();
   end

   initial begin
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, ext_lvl, in_lvl} = '0;
      ofn       = '0;
      err_total = 0;
      checked   = 0;
      rst_b_i   = 1'b0;
      void'($urandom(32'h3a9bce93));
      repeat (6) @(posedge mclk_i);
      rst_b_i <= 1'b1;
      rd(OFF_DRIVE, rv);
      chk(rv, 12'h0, "drive reset");
      rd(OFF_FSEL_B, rv);
      chk(rv, 12'h0, "select b reset");
      chk({boe, bo, poe, po}, 12'h0, "pins after reset");
      $display("Test reset done");
      for (int i = 0; i < 24; i++) begin
         d = (i == 0) ? 8'hff : 8'($urandom);
         @(posedge mclk_i);
         for (int k = 0; k < 5; k++) ofn[k] <= (i == 0) ? 4'h1 : 4'($urandom_range(0, 4));
         wr(OFF_DRIVE, d);
         rd(OFF_DRIVE, rv);
         chk(rv, d & DRIVE_WMASK, "drive readback");
         de = drive_exp(d, ofn);
         chk({boe, bo}, de[9:8], "bidir drive");
         chk({poe, po}, de[7:0], "out drive");
      end
      $display("Test drive done");
      for (int p = 0; p < 4; p++) begin
         for (int c = 0; c < 8; c++) begin
            lv = 4'($urandom);
            @(posedge mclk_i);
            in_lvl <= lv;
            // Reserved bits are set on purpose; they must not stick
            v = (p % 2 == 0) ? (8'h88 | 8'(c << 4)) : (8'h88 | 8'(c));
            wr(OFF_FSEL_A, (p < 2) ? v : 8'h88);
            wr(OFF_FSEL_B, (p >= 2) ? v : 8'h88);
            repeat (3) @(posedge mclk_i);
            rd((p < 2) ? OFF_FSEL_A : OFF_FSEL_B, rv);
            chk(rv, v & FSEL_WMASK, "select readback");
            rd(OFF_IN_MON, rv);
            chk(rv, (c == 1) ? ({lv[p], 7'h00} >> p) : 8'h0, "in monitor");
            re = route_exp(3'(c), lv[p]);
            chk({mv, mo & mv, dv, dd & dv}, re[11:8], "route");
            chk({pv, pd & pv}, re[7:0], "pdm route");
         end
      end
      $display("Test input select done");
      for (int i = 0; i < 12; i++) begin
         f = (i < 3) ? 4'(i) : 4'($urandom_range(0, 2));
         @(posedge mclk_i);
         ofn[0]  <= f;
         ext_lvl <= 1'($urandom);
         wr(OFF_DRIVE, 8'($urandom));
         repeat (3) @(posedge mclk_i);
         rd(OFF_BIDIR_MON, rv);
         chk(rv, (f == BIDIR_FN_GPI) ? {ext_lvl, 7'h00} : 8'h00, "bidir monitor");
      end
      $display("Test bidir monitor done");
      wr(8'h2d, 8'hff);
      rd(8'h2d, rv);
      chk(rv, 12'h0, "unmapped read");
      $display("Test unmapped done");
      // Write then read on the very next edge, no idle cycle between
      v = 8'($urandom);
      @(posedge mclk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= OFF_FSEL_B;
      reg_wdata_i <= v;
      @(posedge mclk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b1;
      @(posedge mclk_i);
      reg_rd_i <= 1'b0;
      #1 rv = reg_rdata_o;
      chk(rv, v & FSEL_WMASK, "back to back readback");
      $display("Test back to back done");
      conclude();
   end
endmodule // gppv_top_bench

`default_nettype wire
